/* logic/cal_seq.sv */
// Calibration sequencer of a sigma-delta converter with a Wishbone slave.
// Assumes a filter that presents a fresh 16-bit raw word every output period.
//
// Function
// - Nonzero mode field write always starts new calibration
// - Mode 01 runs zero then full self-calibration
// - Self zero step shorts inputs at gain
// - Self full step converts reference over gain
// - Self-calibration lasts six output periods
// - Last step end clears both mode bits
// - Ready line high from start until word
// - Self-calibration ready after nine periods
// - Ready rises within one modulator cycle
// - Bipolar self zero point is midscale
// - Mode 10 runs system zero-scale step
// - Mode 11 runs system full-scale step
// - System step three periods, ready after four
// - Results stored in zero and full registers
// - Offset and slope at 33 bits, 16-bit result
// - Single system step keeps other coefficient
// - Bipolar system span midscale to full scale
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps

module cal_seq
    import cal_seq_pkg::*;
#(
    parameter int RAW_W = 16  // Width of the filter word
) (
    // Clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              ce,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Filter word from the modulator path
    input  wire logic [RAW_W-1:0]  raw_word,
    // Front end control and status
    output logic                   data_ready_n,
    output logic                   short_inputs,
    output logic                   ref_over_gain,
    output logic      [1:0]        pga_gain,
    output logic                   bipolar,
    output logic                   cal_busy
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    seq_state_t        state, next_state;        // Sequencer state
    logic [1:0]        cal_mode, next_cal_mode;  // Mode field
    logic [1:0]        gain, next_gain;          // Gain select
    logic              bip, next_bip;            // Bipolar range
    logic              self_cal, next_self_cal;  // Running a self-calibration
    logic [3:0]        step_cnt, next_step_cnt;  // Periods in current step
    logic [15:0]       zero_cal, next_zero_cal;  // Zero-scale coefficient
    logic [15:0]       full_cal, next_full_cal;  // Full-scale coefficient
    logic [15:0]       data_reg, next_data_reg;  // Latest result
    logic [15:0]       period, next_period;      // Modulator cycles per word
    logic              data_ready_n_n, next_data_ready_n_n;      // Ready, active low
    logic              ack, next_ack;            // Bus acknowledge
    logic [31:0]       rdat, next_rdat;          // Read data
    logic              shrt, next_shrt;          // Short inputs
    logic              refg, next_refg;          // Reference over gain
    logic [6:0]        mod_cnt, next_mod_cnt;    // Master clocks in mod cycle
    logic [15:0]       per_cnt, next_per_cnt;    // Mod cycles in output period

    // ----------------------------------------------------------------
    // Decoded strobes
    // ----------------------------------------------------------------
    logic              wr_en;     // Write takes effect this edge
    logic              rd_data;   // Data register read completes
    logic              start;     // Calibration command written
    logic              abort;     // Mode written back to normal
    logic [1:0]        wr_mode;   // Mode field being written
    logic              tick;      // End of an output period
    logic              step_end;  // Last period of a step

    assign wr_en   = cyc_i & stb_i & we_i & ack & sel_i[0];
    assign rd_data = cyc_i & stb_i & ~we_i & ack & (adr_i == ADR_DATA);
    assign wr_mode = dat_i[SETUP_MODE_HI:SETUP_MODE_LO];
    assign start   = wr_en & (adr_i == ADR_SETUP) & (wr_mode != MODE_NORMAL);
    assign abort   = wr_en & (adr_i == ADR_SETUP) & (wr_mode == MODE_NORMAL);
    assign tick    = (mod_cnt == 7'(MOD_CLKS - 1)) & (per_cnt >= period - 16'h0001);

    // ----------------------------------------------------------------
    // Result arithmetic
    // ----------------------------------------------------------------
    logic signed [16:0]       diff;    // Raw minus zero point
    logic signed [16:0]       span;    // Full minus zero point
    logic signed [16:0]       span_nz; // Span kept nonzero
    logic signed [CALC_W-1:0] num;     // Scaled offset-corrected input
    logic signed [CALC_W-1:0] quot;    // Slope-corrected value
    logic signed [CALC_W-1:0] res33;   // Value with range offset
    logic [15:0]              result;  // Clamped output word

    // Offset and slope from the two stored points
    always_comb begin
        diff    = $signed({1'b0, raw_word[15:0]}) - $signed({1'b0, zero_cal});
        span    = $signed({1'b0, full_cal}) - $signed({1'b0, zero_cal});
        span_nz = (span == 17'sh00000) ? 17'sh00001 : span;
        // Bipolar puts the zero point at midscale and spans half the code
        if (bip) begin
            num = {{16{diff[16]}}, diff} <<< 15;
        end else begin
            num = {{16{diff[16]}}, diff} <<< 16;
        end
        quot  = num / {{16{span_nz[16]}}, span_nz};
        res33 = bip ? quot + 33'sh000008000 : quot;
        // Clamp to the 16-bit output code
        if (res33 < 33'sh000000000) begin
            result = 16'h0000;
        end else if (res33 > 33'sh00000FFFF) begin
            result = 16'hFFFF;
        end else begin
            result = res33[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Output period timing
    // ----------------------------------------------------------------

    // Modulator cycle and output period counters, realigned by a command
    always_comb begin
        next_mod_cnt = mod_cnt + 7'h01;
        next_per_cnt = per_cnt;
        if (mod_cnt == 7'(MOD_CLKS - 1)) begin
            next_mod_cnt = 7'h00;
            next_per_cnt = tick ? 16'h0000 : per_cnt + 16'h0001;
        end
        // A command restarts period counting from its own edge
        if (start) begin
            next_mod_cnt = 7'h00;
            next_per_cnt = 16'h0000;
        end
    end

    // Timing registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mod_cnt <= 7'h00;
            per_cnt <= 16'h0000;
        end else if (ce) begin
            mod_cnt <= next_mod_cnt;
            per_cnt <= next_per_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer and registers
    // ----------------------------------------------------------------
    assign step_end = tick & (step_cnt == STEP_PERIODS - 4'h1);

    // Next state, coefficients, bus answers
    always_comb begin
        next_state    = state;
        next_cal_mode = cal_mode;
        next_gain     = gain;
        next_bip      = bip;
        next_self_cal = self_cal;
        next_step_cnt = tick ? step_cnt + 4'h1 : step_cnt;
        next_zero_cal = zero_cal;
        next_full_cal = full_cal;
        next_data_reg = data_reg;
        next_period   = period;
        next_data_ready_n_n   = data_ready_n_n;
        next_ack      = cyc_i & stb_i & ~ack;
        next_rdat     = rdat;

        // Reading the word releases the ready line; a word that lands in
        // the same cycle overrides it below, so a fresh result is never lost
        if (rd_data) begin
            next_data_ready_n_n = 1'b1;
        end

        // Sequencer steps
        case (state)
            ST_IDLE: begin
                // Normal conversion, one word per period
                if (tick) begin
                    next_data_reg = result;
                    next_data_ready_n_n   = 1'b0;
                end
            end
            ST_ZERO: begin
                if (step_end) begin
                    next_zero_cal = raw_word[15:0];
                    next_step_cnt = 4'h0;
                    if (self_cal) begin
                        next_state = ST_FULL;
                    end else begin
                        next_cal_mode = MODE_NORMAL;
                        next_state    = ST_TAIL;
                    end
                end
            end
            ST_FULL: begin
                if (step_end) begin
                    next_full_cal = raw_word[15:0];
                    next_cal_mode = MODE_NORMAL;
                    next_step_cnt = 4'h0;
                    next_state    = ST_TAIL;
                end
            end
            ST_TAIL: begin
                // Conversion on the input and coefficient setup
                if (tick && (step_cnt == (self_cal ? SELF_TAIL : SYS_TAIL) - 4'h1)) begin
                    next_data_reg = result;
                    next_data_ready_n_n   = 1'b0;
                    next_step_cnt = 4'h0;
                    next_state    = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        // Register writes
        if (wr_en) begin
            case (adr_i)
                ADR_SETUP: begin
                    next_cal_mode = wr_mode;
                    next_gain     = dat_i[SETUP_GAIN_HI:SETUP_GAIN_LO];
                    next_bip      = dat_i[SETUP_BIPOLAR];
                end
                ADR_ZERO: begin
                    next_zero_cal = dat_i[15:0];
                end
                ADR_FULL: begin
                    next_full_cal = dat_i[15:0];
                end
                ADR_PERIOD: begin
                    next_period = (dat_i[15:0] == 16'h0000) ? 16'h0001 : dat_i[15:0];
                end
                default: begin
                    next_period = period;
                end
            endcase
        end

        // A command preempts whatever is running
        if (start) begin
            next_step_cnt = 4'h0;
            next_data_ready_n_n   = 1'b1;
            next_self_cal = (wr_mode == MODE_SELF);
            if (wr_mode == MODE_SYS_FULL) begin
                next_state = ST_FULL;
            end else begin
                next_state = ST_ZERO;
            end
        end else if (abort) begin
            next_state    = ST_IDLE;
            next_step_cnt = 4'h0;
        end

        // Read data captured as the acknowledge rises
        if (cyc_i && stb_i && !ack) begin
            case (adr_i)
                ADR_SETUP:  next_rdat = {27'h0, bip, gain, cal_mode};
                ADR_STATUS: next_rdat = {26'h0, state, cal_busy, data_ready_n_n};
                ADR_ZERO:   next_rdat = {16'h0, zero_cal};
                ADR_FULL:   next_rdat = {16'h0, full_cal};
                ADR_DATA:   next_rdat = {16'h0, data_reg};
                ADR_PERIOD: next_rdat = {16'h0, period};
                default:    next_rdat = 32'h00000000;
            endcase
        end

        // Front end steering follows the next state
        next_shrt = (next_state == ST_ZERO) & next_self_cal;
        next_refg = (next_state == ST_FULL) & next_self_cal;
    end

    // Sequencer registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state    <= ST_IDLE;
            cal_mode <= MODE_NORMAL;
            gain     <= 2'h0;
            bip      <= 1'b0;
            self_cal <= 1'b0;
            step_cnt <= 4'h0;
            zero_cal <= ZERO_RST;
            full_cal <= FULL_RST;
            data_reg <= 16'h0000;
            period   <= PERIOD_RST;
            data_ready_n_n   <= 1'b1;
            ack      <= 1'b0;
            rdat     <= 32'h00000000;
            shrt     <= 1'b0;
            refg     <= 1'b0;
        end else if (ce) begin
            state    <= next_state;
            cal_mode <= next_cal_mode;
            gain     <= next_gain;
            bip      <= next_bip;
            self_cal <= next_self_cal;
            step_cnt <= next_step_cnt;
            zero_cal <= next_zero_cal;
            full_cal <= next_full_cal;
            data_reg <= next_data_reg;
            period   <= next_period;
            data_ready_n_n   <= next_data_ready_n_n;
            ack      <= next_ack;
            rdat     <= next_rdat;
            shrt     <= next_shrt;
            refg     <= next_refg;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign dat_o         = rdat;
    assign ack_o         = ack;
    assign data_ready_n  = data_ready_n_n;
    assign short_inputs  = shrt;
    assign ref_over_gain = refg;
    assign pga_gain      = gain;
    assign bipolar       = bip;
    assign cal_busy      = (state != ST_IDLE);

endmodule // cal_seq

/* logic/cal_seq_pkg.sv */
// Constants shared by the calibration sequencer and its bench.
// Assumes a 32-bit classic Wishbone register bus and a 100 MHz system clock.
package cal_seq_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_SETUP  = 8'h00;  // Mode, gain, polarity
    localparam logic [7:0] ADR_STATUS = 8'h04;  // Ready, busy, state
    localparam logic [7:0] ADR_ZERO   = 8'h08;  // Zero-scale coefficient
    localparam logic [7:0] ADR_FULL   = 8'h0C;  // Full-scale coefficient
    localparam logic [7:0] ADR_DATA   = 8'h10;  // Conversion result
    localparam logic [7:0] ADR_PERIOD = 8'h14;  // Output period, modulator cycles

    // ----------------------------------------------------------------
    // Setup register fields
    // ----------------------------------------------------------------
    localparam int SETUP_MODE_LO = 0;  // cal_mode_low_bit
    localparam int SETUP_MODE_HI = 1;  // cal_mode_high_bit
    localparam int SETUP_GAIN_LO = 2;  // gain_select_low
    localparam int SETUP_GAIN_HI = 3;  // gain_select_high
    localparam int SETUP_BIPOLAR = 4;  // Bipolar range when set

    // Calibration mode codes
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_SELF     = 2'h1;
    localparam logic [1:0] MODE_SYS_ZERO = 2'h2;
    localparam logic [1:0] MODE_SYS_FULL = 2'h3;

    // ----------------------------------------------------------------
    // Reset values and timing counts
    // ----------------------------------------------------------------
    localparam logic [15:0] ZERO_RST    = 16'h0000;  // Nominal zero point
    localparam logic [15:0] FULL_RST    = 16'hFFFF;  // Nominal full-scale point
    localparam logic [15:0] PERIOD_RST  = 16'h0096;  // Modulator cycles per word
    localparam int          MOD_CLKS    = 128;       // Master clocks per mod cycle
    localparam logic [3:0]  STEP_PERIODS = 4'h3;     // Periods per calibration step
    localparam logic [3:0]  SELF_TAIL   = 4'h3;      // Input conversion and setup
    localparam logic [3:0]  SYS_TAIL    = 4'h1;      // One normal conversion
    localparam int          CALC_W      = 33;        // Internal arithmetic width

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ZERO = 4'b0010,
        ST_FULL = 4'b0100,
        ST_TAIL = 4'b1000
    } seq_state_t;

endpackage

/* tb/cal_seq_assertions.sv */
// Checker of bus handshake and calibration timing at the sequencer ports.
// Assumes the output period is set over the bus.
`timescale 1ns/1ps
module cal_seq_checker
    import cal_seq_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        ce,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    input wire logic        data_ready_n,
    input wire logic        short_inputs,
    input wire logic        ref_over_gain,
    input wire logic        cal_busy
);
    logic        wr_ok, start, pend;         // Write taken, command taken, ready due
    logic [1:0]  mode;                       // Mode of the last command
    logic [31:0] per, sh_cnt, rf_cnt, since; // Period and cycle counters
    assign wr_ok = ack_o && cyc_i && stb_i && we_i && sel_i[0] && ce;
    assign start = wr_ok && adr_i == ADR_SETUP && dat_i[1:0] != MODE_NORMAL;
    // Follow the period, the step lengths and the wait for ready
    always_ff @(posedge clk_sys) begin
        // A new command restarts the step counts even if a step is running
        sh_cnt <= (short_inputs && !start) ? sh_cnt + 32'h1 : 32'h0;
        rf_cnt <= (ref_over_gain && !start) ? rf_cnt + 32'h1 : 32'h0;
        since  <= start ? 32'h0 : since + 32'h1;
        mode   <= start ? dat_i[1:0] : mode;
        if (reset) begin
            per  <= 32'(PERIOD_RST);
            pend <= 1'b0;
        end else begin
            if (wr_ok && adr_i == ADR_PERIOD)
                per <= (dat_i[15:0] == 16'h0) ? 32'h1 : 32'(dat_i[15:0]);
            if (start)
                pend <= 1'b1;
            else if (!data_ready_n || (wr_ok && adr_i == ADR_SETUP))
                pend <= 1'b0;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_cmd;
        start;
    endsequence
    sequence s_ready_up;
        ##[1:128] data_ready_n;
    endsequence
    AST_READY_RISE: assert property (s_cmd |-> s_ready_up)
        else $error("ready not raised after command");
    AST_READY_HELD: assert property (short_inputs || ref_over_gain |-> data_ready_n)
        else $error("ready low inside a step");
    AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_SHORT_ZERO: assert property (short_inputs |-> cal_busy && !ref_over_gain)
        else $error("shorted inputs outside zero step");
    AST_ZERO_LEN: assert property ($rose(ref_over_gain) |-> sh_cnt == 384 * per)
        else $error("zero step length wrong");
    AST_FULL_LEN: assert property ($fell(ref_over_gain) && cal_busy && !$past(start)
        |-> rf_cnt == 384 * per)
        else $error("full step length wrong");
    AST_SELF_READY: assert property ($fell(data_ready_n) && pend && mode == MODE_SELF
        |-> since + 3 >= 1152 * per && since <= 1152 * per + 3)
        else $error("self ready delay wrong");
    AST_SYS_READY: assert property ($fell(data_ready_n) && pend && mode != MODE_SELF
        |-> since + 3 >= 512 * per && since <= 512 * per + 3)
        else $error("system ready delay wrong");
endmodule // cal_seq_checker
bind cal_seq cal_seq_checker u_chk (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .data_ready_n(data_ready_n), .short_inputs(short_inputs),
    .ref_over_gain(ref_over_gain), .cal_busy(cal_busy)
);

/* tb/wb_host_model.sv */
// Host model: classic Wishbone master, one single cycle at a time.
// Assumes one caller process and a slave that answers with ack.
`timescale 1ns/1ps
module wb_host_model (
    // Clock and answer
    input  wire logic   clk_sys,
    input  wire logic   ack_o,
    // Request
    output logic        cyc_i,
    output logic        stb_i,
    output logic        we_i,
    output logic [7:0]  adr_i,
    output logic [3:0]  sel_i,
    output logic [31:0] dat_i
);
    // Bus idle at time zero
    initial begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    end
    // One cycle; ready is not looked at while a command lands
    task automatic cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hF, d};
        do @(posedge clk_sys); while (ack_o !== 1'b1);
        {cyc_i, stb_i} <= 2'b00;
        adr_i <= ~a;
        dat_i <= ~d;
    endtask
endmodule // wb_host_model

/* tb/cal_seq_bench.sv */
// Bench: host model on the bus, a front-end stub on the filter word.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
module cal_seq_bench;
    import cal_seq_pkg::*;
    logic        clk_sys = 1'b0;                  // 100 MHz clock
    logic        reset = 1'b1;                    // Held 20 cycles
    logic        ce = 1'b1;                       // Running except for the frozen-ready check
    logic        cyc_i, stb_i, we_i, ack_o;       // Bus handshake
    logic [7:0]  adr_i;                           // Byte address
    logic [3:0]  sel_i;                           // Byte enables
    logic [31:0] dat_i, dat_o;                    // Bus data
    logic [15:0] raw_word = 16'h0;                // Filter word
    logic        data_ready_n, short_inputs, ref_over_gain, bipolar, cal_busy;
    logic [1:0]  pga_gain, g;                     // Seen and chosen gain
    logic [15:0] zv, fv, analog_input, ez, ef;             // Stub levels, coefficients
    logic [31:0] exp_q[$];                        // Expected read words
    int          err_count = 0;
    int          total_checks = 0;
    int          cyc = 0;                         // Cycle count
    int          t0;                              // Cycle of last command
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    // Front end: shorted level, reference level or analog input
    always @(posedge clk_sys) raw_word <= short_inputs ? zv : ref_over_gain ? fv : analog_input;
    cal_seq u_dut (
        .clk_sys(clk_sys), .reset(reset), .ce(ce), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .raw_word(raw_word), .data_ready_n(data_ready_n),
        .short_inputs(short_inputs), .ref_over_gain(ref_over_gain),
        .pga_gain(pga_gain), .bipolar(bipolar), .cal_busy(cal_busy)
    );
    wb_host_model u_host (
        .clk_sys(clk_sys), .ack_o(ack_o), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i)
    );
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    // Expected output word from the stored coefficients
    function automatic logic [31:0] conv(input logic [15:0] r, input logic b);
        longint d, s, v;
        d = longint'(r) - longint'(ez);
        s = (ef == ez) ? 1 : longint'(ef) - longint'(ez);
        v = b ? 32768 + d * 32768 / s : d * 65536 / s;
        return 32'((v < 0) ? 0 : (v > 65535) ? 65535 : v);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.cycle(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_host.cycle(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [1:0] m, input logic b);
        wr(ADR_SETUP, {27'h0, b, g, m});
        t0 = cyc;
    endtask
    task automatic wait_rdy(input int dly);
        repeat (MOD_CLKS) @(posedge clk_sys);
        while (data_ready_n !== 1'b0 && cyc - t0 < dly + 50) @(posedge clk_sys);
        chk("ready delay", 1, cyc - t0 >= dly - 3 && cyc - t0 <= dly + 3);
    endtask
    task automatic sys_step(input logic [1:0] m, input logic [15:0] v);
        analog_input <= v;
        @(posedge clk_sys);
        cmd(m, 1'b0);
        wait_rdy(512);
        ez = (m == MODE_SYS_ZERO) ? v : ez;
        ef = (m == MODE_SYS_FULL) ? v : ef;
        rd(ADR_ZERO, {16'h0, ez});
        rd(ADR_FULL, {16'h0, ef});
        rd(ADR_DATA, conv(v, 1'b0));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Compare each read answer with the oldest note
    always @(posedge clk_sys) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
            chk("read word", exp_q.pop_front(), dat_o);
    end
    // Hang guard, well beyond the few thousand cycles of the run
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(31));
        zv = 16'h0100 + 16'($urandom_range(255));
        fv = zv + 16'h8000;
        analog_input = zv + 16'($urandom_range(32767));
        g = 2'($urandom_range(3));
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        rd(ADR_SETUP, 32'h0);
        rd(ADR_STATUS, 32'h5);
        rd(ADR_ZERO, {16'h0, ZERO_RST});
        rd(ADR_FULL, {16'h0, FULL_RST});
        rd(ADR_PERIOD, {16'h0, PERIOD_RST});
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0);
        wr(ADR_PERIOD, 32'h1);
        cmd(MODE_SELF, 1'b0);
        repeat (2) @(posedge clk_sys);
        chk("short", 1, short_inputs);
        chk("ready_n", 1, data_ready_n);
        chk("gain", g, pga_gain);
        repeat (384) @(posedge clk_sys);
        chk("ref", 1, ref_over_gain);
        rd(ADR_SETUP, {28'h0, g, MODE_SELF});
        repeat (384) @(posedge clk_sys);
        rd(ADR_SETUP, {28'h0, g, MODE_NORMAL});
        wait_rdy(1152);
        ez = zv;
        ef = fv;
        rd(ADR_ZERO, {16'h0, zv});
        rd(ADR_FULL, {16'h0, fv});
        rd(ADR_DATA, conv(analog_input, 1'b0));
        sys_step(MODE_SYS_ZERO, zv + 16'h0010);
        sys_step(MODE_SYS_FULL, zv + 16'h7000);
        sys_step(MODE_SYS_ZERO, zv + 16'h0020);
        analog_input <= ez + 16'h37F0;
        cmd(MODE_NORMAL, 1'b1);
        repeat (300) @(posedge clk_sys);
        while (data_ready_n !== 1'b0) @(posedge clk_sys);
        chk("bipolar", 1, bipolar);
        rd(ADR_DATA, conv(ez + 16'h37F0, 1'b1));
        repeat (2) @(posedge clk_sys);
        chk("ready_n", 1, data_ready_n);
        cmd(MODE_SELF, 1'b0);
        repeat (100) @(posedge clk_sys);
        cmd(MODE_NORMAL, 1'b0);
        repeat (2) @(posedge clk_sys);
        chk("busy", 0, cal_busy);
        rd(ADR_ZERO, {16'h0, ez});
        // Next idle word is unipolar again; then a frozen clock enable holds ready
        while (data_ready_n !== 1'b0) @(posedge clk_sys);
        rd(ADR_DATA, conv(ez + 16'h37F0, 1'b0));
        ce <= 1'b0;
        repeat (300) @(posedge clk_sys);
        chk("frozen ready_n", 1, data_ready_n);
        ce <= 1'b1;
        repeat (3) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule // cal_seq_bench
